// [wdpr_pkg.sv]
// shared constants and types for the watchdog, power and reset control block
package wdpr_pkg;
   // register addresses in the special-function-register space
   localparam logic [7:0] POWER_CONTROL_ADDR = 8'h87;
   localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'h8f;
   // reset values: ports, stack pointer, every other register except the power-on flag, which resets to POF_RESET
   localparam logic [7:0] PORT_RESET = 8'hff;
   localparam logic [7:0] SP_RESET = 8'h07;
   localparam logic [7:0] SFR_RESET = 8'h00;
   // power_control bit positions
   localparam int POWER_CONTROL_POF = 4;
   localparam int POWER_CONTROL_GF1 = 3;
   localparam int POWER_CONTROL_GF0 = 2;
   localparam int POWER_CONTROL_PD = 1;
   localparam int POWER_CONTROL_IDL = 0;
   // watchdog_control bit positions and writable bits
   localparam int WATCHDOG_CONTROL_WATCHDOG_CLEAR_BIT = 6;
   localparam logic [7:0] WATCHDOG_CONTROL_WMASK = 8'he7;
   // timing: oscillator at 50 MHz, one machine cycle is 12 oscillator periods
   localparam int OSC_PERIOD_NS = 20;
   localparam int MC_OSC_PERIODS = 12;
   localparam logic [2:0] ST_LAST = 3'(MC_OSC_PERIODS / 2 - 1);
   localparam logic [2:0] ST_SAMPLE = 3'h4;
   // watchdog reset pulse length
   localparam int WD_RST_MC = 2;
   localparam logic [4:0] WD_RST_CLKS = 5'(WD_RST_MC * MC_OSC_PERIODS);
   localparam logic [13:0] WD_CNT_LAST = 14'h3fff;
   localparam logic POF_RESET = 1'b1;

   typedef enum logic [1:0] {WDPR_RUN, WDPR_IDLE, WDPR_PDOWN} wdpr_mode_t;

   typedef struct packed {
      logic watchdog_enable_bit;
      logic watchdog_clear_bit;
      logic watchdog_idle_run;
      logic [1:0] rsv;
      logic [2:0] ps;
   } wdpr_watchdog_control_t;

   typedef struct packed {
      logic [2:0] rsv;
      logic power_on_flag;
      logic gf1;
      logic gf0;
      logic pd;
      logic sleep_request_bit;
   } wdpr_power_control_t;
endpackage : wdpr_pkg

// [wdpr_ctrl.sv]
// watchdog timer, power modes and reset sampling of the microcontroller system block
`timescale 1ns/1ns
// How it works
// - watchdog is a prescaler and counter chain run from the system clock
// - timeout with watchdog_enable_bit set raises a full system reset
// - any reset disables the watchdog and clears its counter
// - bit 7 watchdog_enable_bit turns on counting and the timeout reset
// - writing watchdog_clear_bit zeroes counter and prescaler next machine cycle, then self-clears
// - watchdog_idle_run lets the watchdog count in idle; clear halts it there
// - prescale_select picks divide 2,4,8,16,32,64,128,256 by the coded table
// - timeout is 2^14 times prescaler ratio times 12 oscillator periods
// - oscillator clock is halved before internal use
// - sleep_request_bit stops the processor clock, peripherals keep running
// - any interrupt or reset leaves idle mode
// - power_down_bit stops every clock; only a reset leaves power-down
// - power_on_flag set on power-on, software clearable, kept over other resets
// - user_flag_one and user_flag_zero are plain storage bits
// - reset pin sampled at sample_state_slot, must stand high two machine cycles
// - reset pin path ignores short glitches
// - reset loads registers with their documented reset values
module wdpr_ctrl
   import wdpr_pkg::*;
(
   input logic sys_clk,
   input logic rst_n,
   input logic [7:0] reg_addr,
   input logic [7:0] reg_wdata,
   input logic reg_wr,
   input logic reg_rd,
   output logic [7:0] reg_rdata,
   input logic rst_pin,
   input logic irq_any,
   output logic cpu_clk_en,
   output logic periph_clk_en,
   output logic osc_run,
   output logic sys_reset
);

   wdpr_mode_t mode;
   wdpr_watchdog_control_t watchdog_control;
   logic power_on_flag;
   logic gf1;
   logic gf0;
   logic half;
   logic [2:0] st;
   logic osc_en;
   logic mc_tick;
   logic slot;
   logic [1:0] pin_hist;
   logic pin_reset;
   logic [4:0] wd_rst_cnt;
   logic int_reset;
   logic [7:0] presc;
   logic [13:0] wd_cnt;
   logic [7:0] presc_last;
   logic wd_run;
   logic wd_expire;
   logic wr_power_control;
   logic wr_watchdog_control;
   wdpr_power_control_t power_control_view;

   assign wr_power_control = reg_wr && reg_addr == POWER_CONTROL_ADDR;
   assign wr_watchdog_control = reg_wr && reg_addr == WATCHDOG_CONTROL_ADDR;

   ////////////////////////////////////////////////////////////////////////////
   // machine timing
   // oscillator stops
   // the reset pin restarts the oscillator so the pin can be sampled at all
   assign osc_en = mode != WDPR_PDOWN || rst_pin;

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         half <= 1'b0;
      end else if (osc_en) begin
         half <= ~half;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         st <= 3'h0;
      end else if (osc_en && half) begin
         st <= (st == ST_LAST) ? 3'h0 : st + 3'h1;
      end
   end

   assign mc_tick = osc_en && half && st == ST_LAST;
   assign slot = osc_en && half && st == ST_SAMPLE;

   ////////////////////////////////////////////////////////////////////////////
   // reset sources
   // sample and deglitch
   // a single high sample is a glitch; two consecutive slots make a reset
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pin_hist <= 2'h0;
      end else if (slot) begin
         pin_hist <= {pin_hist[0], rst_pin};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         pin_reset <= 1'b0;
      end else begin
         pin_reset <= &pin_hist;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         wd_rst_cnt <= 5'h0;
      end else if (wd_expire) begin
         wd_rst_cnt <= WD_RST_CLKS;
      end else if (wd_rst_cnt != 5'h0) begin
         wd_rst_cnt <= wd_rst_cnt - 5'h1;
      end
   end

   assign int_reset = pin_reset || wd_rst_cnt != 5'h0;

   ////////////////////////////////////////////////////////////////////////////
   // watchdog
   // prescaler table
   always_comb begin
      unique case (watchdog_control.ps)
         3'b000: presc_last = 8'h01;
         3'b010: presc_last = 8'h03;
         3'b001: presc_last = 8'h07;
         3'b011: presc_last = 8'h0f;
         3'b100: presc_last = 8'h1f;
         3'b101: presc_last = 8'h3f;
         3'b110: presc_last = 8'h7f;
         3'b111: presc_last = 8'hff;
      endcase
   end

   assign wd_run = watchdog_control.watchdog_enable_bit && osc_en && (mode == WDPR_RUN || (mode == WDPR_IDLE && watchdog_control.watchdog_idle_run));

   assign wd_expire = wd_run && mc_tick && !watchdog_control.watchdog_clear_bit && !int_reset && presc == presc_last && wd_cnt == WD_CNT_LAST;

   // divider chain
   // one step per machine cycle, so the 12-period factor comes for free
   always_ff @(posedge sys_clk) begin
      if (!rst_n || int_reset) begin
         presc <= 8'h00;
         wd_cnt <= 14'h0000;
      end else if (watchdog_control.watchdog_clear_bit && mc_tick) begin
         presc <= 8'h00;
         wd_cnt <= 14'h0000;
      end else if (wd_run && mc_tick) begin
         if (presc == presc_last) begin
            presc <= 8'h00;
            wd_cnt <= wd_cnt + 14'h0001;
         end else begin
            presc <= presc + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   // watchdog control register
   always_ff @(posedge sys_clk) begin
      if (!rst_n || int_reset) begin
         watchdog_control <= wdpr_watchdog_control_t'(SFR_RESET);
      end else begin
         if (wr_watchdog_control) begin
            watchdog_control.watchdog_enable_bit <= reg_wdata[7];
            watchdog_control.watchdog_idle_run <= reg_wdata[5];
            watchdog_control.ps <= reg_wdata[2:0];
         end
         // self-clear
         // a new write wins over the automatic clear in the same cycle
         if (wr_watchdog_control && reg_wdata[WATCHDOG_CONTROL_WATCHDOG_CLEAR_BIT]) begin
            watchdog_control.watchdog_clear_bit <= 1'b1;
         end else if (mc_tick) begin
            watchdog_control.watchdog_clear_bit <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || int_reset) begin
         mode <= WDPR_RUN;
      end else begin
         unique case (mode)
            WDPR_RUN: begin
               if (wr_power_control && reg_wdata[POWER_CONTROL_PD]) begin
                  mode <= WDPR_PDOWN;
               end else if (wr_power_control && reg_wdata[POWER_CONTROL_IDL]) begin
                  mode <= WDPR_IDLE;
               end
            end
            WDPR_IDLE: begin
               if (irq_any) begin
                  mode <= WDPR_RUN;
               end
            end
            WDPR_PDOWN: begin
               mode <= WDPR_PDOWN;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         power_on_flag <= POF_RESET;
      end else if (wr_power_control && !int_reset) begin
         power_on_flag <= reg_wdata[POWER_CONTROL_POF];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rst_n || int_reset) begin
         gf1 <= 1'b0;
         gf0 <= 1'b0;
      end else if (wr_power_control) begin
         gf1 <= reg_wdata[POWER_CONTROL_GF1];
         gf0 <= reg_wdata[POWER_CONTROL_GF0];
      end
   end

   always_comb begin
      power_control_view = wdpr_power_control_t'(SFR_RESET);
      power_control_view.power_on_flag = power_on_flag;
      power_control_view.gf1 = gf1;
      power_control_view.gf0 = gf0;
      power_control_view.pd = mode == WDPR_PDOWN;
      power_control_view.sleep_request_bit = mode == WDPR_IDLE;
   end

   // read data stand one cycle only; unmapped reads return zero
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         reg_rdata <= SFR_RESET;
      end else if (reg_rd && reg_addr == POWER_CONTROL_ADDR) begin
         reg_rdata <= power_control_view;
      end else if (reg_rd && reg_addr == WATCHDOG_CONTROL_ADDR) begin
         reg_rdata <= watchdog_control & WATCHDOG_CONTROL_WMASK;
      end else begin
         reg_rdata <= SFR_RESET;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cpu_clk_en <= 1'b1;
         periph_clk_en <= 1'b1;
         osc_run <= 1'b1;
         sys_reset <= 1'b1;
      end else begin
         cpu_clk_en <= mode == WDPR_RUN;
         periph_clk_en <= mode != WDPR_PDOWN;
         osc_run <= osc_en;
         sys_reset <= int_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   property p_clr_self;
      watchdog_control.watchdog_clear_bit && mc_tick && !wr_watchdog_control |=> !watchdog_control.watchdog_clear_bit;
   endproperty
   a_clr_self: assert property (p_clr_self) else $error("clear bit not self-cleared");

   property p_clr_zero;
      watchdog_control.watchdog_clear_bit && mc_tick |=> wd_cnt == 14'h0000 && presc == 8'h00;
   endproperty
   a_clr_zero: assert property (p_clr_zero) else $error("clear did not zero watchdog");

   property p_hold;
      !wd_run && !int_reset && !(watchdog_control.watchdog_clear_bit && mc_tick) |=> $stable(wd_cnt) && $stable(presc);
   endproperty
   a_hold: assert property (p_hold) else $error("halted watchdog moved");

   property p_timeout;
      wd_expire |-> ##2 sys_reset ##1 !watchdog_control.watchdog_enable_bit;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout gave no reset");

   property p_rst_off;
      int_reset |=> !watchdog_control.watchdog_enable_bit && wd_cnt == 14'h0000 && mode == WDPR_RUN;
   endproperty
   a_rst_off: assert property (p_rst_off) else $error("reset left watchdog on");

   property p_pof_keep;
      int_reset |=> power_on_flag == $past(power_on_flag);
   endproperty
   a_pof_keep: assert property (p_pof_keep) else $error("power-on flag lost on warm reset");

   property p_idle_wake;
      mode == WDPR_IDLE && irq_any |=> mode == WDPR_RUN ##1 cpu_clk_en;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("interrupt did not end idle");

   property p_both;
      mode == WDPR_RUN && !int_reset && wr_power_control && reg_wdata[POWER_CONTROL_PD] && reg_wdata[POWER_CONTROL_IDL] |=> mode == WDPR_PDOWN;
   endproperty
   a_both: assert property (p_both) else $error("combined request missed power-down");

   property p_pd_stop;
      mode == WDPR_PDOWN && !rst_pin |=> !osc_run && !periph_clk_en && !cpu_clk_en;
   endproperty
   a_pd_stop: assert property (p_pd_stop) else $error("clock runs in power-down");

   property p_pin;
      slot && rst_pin && pin_hist[0] |-> ##3 sys_reset;
   endproperty
   a_pin: assert property (p_pin) else $error("held reset pin ignored");

   property p_glitch;
      !pin_hist[1] && !pin_hist[0] && !slot && wd_rst_cnt == 5'h0 && !wd_expire |=> !int_reset;
   endproperty
   a_glitch: assert property (p_glitch) else $error("glitch reached reset");

   property p_half;
      osc_en |=> half != $past(half);
   endproperty
   a_half: assert property (p_half) else $error("clock halving stalled");

   c_timeout: cover property (wd_expire);
   c_idle_wake: cover property (mode == WDPR_IDLE && irq_any);
   c_pin_reset: cover property ($rose(pin_reset));
   c_clear: cover property (watchdog_control.watchdog_clear_bit && mc_tick && wd_cnt != 14'h0000);
endmodule : wdpr_ctrl

// [wdpr_rst_src.sv]
// external reset source model driving the reset pin
`timescale 1ns/1ns
module wdpr_rst_src (
   input logic sys_clk,
   input logic fire,
   input logic [7:0] hold_clks,
   output logic rst_pin
);
   logic [7:0] left = 8'h00;
   // pin held high for the asked count
   always_ff @(posedge sys_clk) begin
      if (fire) begin
         left <= hold_clks;
      end else if (left != 8'h00) begin
         left <= left - 8'h01;
      end
   end
   // pin idles low, a pulse of one machine cycle or shorter is always a glitch
   assign rst_pin = (left != 8'h00);
endmodule : wdpr_rst_src

// [watchdog_power_reset_ctrl_tb_top.sv]
// self-checking bench for the watchdog, power and reset control block
`timescale 1ns/1ns
module watchdog_power_reset_ctrl_tb_top;
   import wdpr_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic rst_pin;
   logic irq_any = 1'b0;
   logic cpu_clk_en, periph_clk_en, osc_run, sys_reset;
   logic fire = 1'b0;
   logic [7:0] hold_clks = 8'h00;
   int miscompares = 0;
   int checks_done = 0;
   int cyc = 0;
   always #10 sys_clk = ~sys_clk;
   wdpr_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rst_pin(rst_pin), .irq_any(irq_any),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_run(osc_run), .sys_reset(sys_reset));
   wdpr_rst_src src_u (.sys_clk(sys_clk), .fire(fire), .hold_clks(hold_clks), .rst_pin(rst_pin));
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd
   task automatic idle_clks(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : idle_clks
   // pulse the reset pin, return whether sys_reset rose within the wait
   task automatic pin_pulse(input logic [7:0] n, output logic seen);
      seen = 1'b0;
      @(posedge sys_clk);
      fire <= 1'b1;
      hold_clks <= n;
      @(posedge sys_clk);
      fire <= 1'b0;
      repeat (60) begin
         @(posedge sys_clk);
         #1;
         if (sys_reset === 1'b1) seen = 1'b1;
      end
      for (int i = 0; i < 60 && sys_reset !== 1'b0; i++) idle_clks(1);
   endtask : pin_pulse
   ////////////////////////////////////////////////////////////////
   task automatic test_reset_values();
      chk({7'h00, sys_reset}, 8'h00);
      rd(POWER_CONTROL_ADDR, 8'h10);
      idle_clks(1);
      chk(reg_rdata, 8'h00);
      rd(WATCHDOG_CONTROL_ADDR, SFR_RESET);
      rd(8'h8e, 8'h00);
   endtask : test_reset_values
   task automatic test_flags();
      wr(POWER_CONTROL_ADDR, 8'h1c);
      rd(POWER_CONTROL_ADDR, 8'h1c);
      wr(POWER_CONTROL_ADDR, 8'h04);
      rd(POWER_CONTROL_ADDR, 8'h04);
      wr(8'h8e, 8'hff);
      rd(POWER_CONTROL_ADDR, 8'h04);
   endtask : test_flags
   task automatic test_wd_clear();
      // clear bit reads back until the next machine tick, then drops by itself
      // two idle clocks put the write just after a tick, so the read-back lands before the next one
      idle_clks(2);
      wr(WATCHDOG_CONTROL_ADDR, 8'h47);
      rd(WATCHDOG_CONTROL_ADDR, 8'h47);
      idle_clks(14);
      rd(WATCHDOG_CONTROL_ADDR, 8'h07);
      wr(WATCHDOG_CONTROL_ADDR, 8'h3a);
      rd(WATCHDOG_CONTROL_ADDR, 8'h22);
      wr(WATCHDOG_CONTROL_ADDR, 8'h00);
   endtask : test_wd_clear
   task automatic test_idle();
      wr(POWER_CONTROL_ADDR, 8'h05);
      idle_clks(3);
      chk({6'h00, cpu_clk_en, periph_clk_en}, 8'h01);
      rd(POWER_CONTROL_ADDR, 8'h05);
      @(posedge sys_clk);
      irq_any <= 1'b1;
      idle_clks(3);
      chk({7'h00, cpu_clk_en}, 8'h01);
      irq_any <= 1'b0;
      rd(POWER_CONTROL_ADDR, 8'h04);
   endtask : test_idle
   task automatic test_pin_reset();
      logic seen;
      wr(POWER_CONTROL_ADDR, 8'h08);
      wr(WATCHDOG_CONTROL_ADDR, 8'h25);
      pin_pulse(8'h0a, seen);
      chk({7'h00, seen}, 8'h00);
      rd(WATCHDOG_CONTROL_ADDR, 8'h25);
      pin_pulse(8'h24, seen);
      chk({7'h00, seen}, 8'h01);
      rd(POWER_CONTROL_ADDR, 8'h00);
      rd(WATCHDOG_CONTROL_ADDR, 8'h00);
   endtask : test_pin_reset
   task automatic test_power_down();
      logic seen;
      wr(POWER_CONTROL_ADDR, 8'h13);
      idle_clks(3);
      chk({5'h00, cpu_clk_en, periph_clk_en, osc_run}, 8'h00);
      @(posedge sys_clk);
      irq_any <= 1'b1;
      idle_clks(4);
      chk({6'h00, periph_clk_en, osc_run}, 8'h00);
      irq_any <= 1'b0;
      pin_pulse(8'h24, seen);
      chk({7'h00, seen}, 8'h01);
      chk({5'h00, cpu_clk_en, periph_clk_en, osc_run}, 8'h07);
      rd(POWER_CONTROL_ADDR, 8'h10);
   endtask : test_power_down
   ////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : tally_and_finish
   // the whole sequence needs well under a thousand cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         $display("mismatch at %0t: run did not finish", $time);
         tally_and_finish();
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      idle_clks(2);
      test_reset_values();
      test_flags();
      test_wd_clear();
      test_idle();
      test_pin_reset();
      test_power_down();
      tally_and_finish();
   end
endmodule : watchdog_power_reset_ctrl_tb_top
